// ===== inc/acs_pkg.sv
package acs_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_MODE   = 8'h00; // operation_mode_field
    localparam logic [7:0] ADDR_STATUS = 8'h04; // sequencer state
    localparam logic [7:0] ADDR_OFFSET = 8'h08; // offset calibration
    localparam logic [7:0] ADDR_FSCALE = 8'h0c; // full-scale calibration
    localparam logic [7:0] ADDR_CONV   = 8'h10; // conversion period
    localparam logic [7:0] ADDR_RESULT = 8'h14; // measured value input
    // ==========================================================
    // mode codes
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SELF   = 3'h1;
    localparam logic [2:0] MODE_SYSOFS = 3'h2;
    localparam logic [2:0] MODE_SYSFS  = 3'h3;
    localparam logic [2:0] MODE_PSEUDO = 3'h4;
    localparam logic [2:0] MODE_BGND   = 3'h5;
    // ==========================================================
    // counts and reset values
    localparam logic [2:0]  CAL_CONVS      = 3'h3; // conversions per cal
    localparam logic [2:0]  CAL_CONVS_SLV  = 3'h4; // slave offset cal
    localparam logic [2:0]  FILL_CONVS     = 3'h3; // filter-fill convs
    localparam logic [2:0]  SYS_FILL_CONVS = 3'h1; // after system cal
    localparam int          CLK_MHZ        = 100;
    localparam int          CONV_US_DEF    = 10;   // default period
    localparam logic [15:0] CONV_CYC_DEF   = 16'(CONV_US_DEF * CLK_MHZ);
    localparam logic [23:0] OFFSET_RST     = 24'h000000;
    localparam logic [23:0] FSCALE_RST     = 24'h800000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OFS, ST_GAIN, ST_FILL, ST_VALID
    } acs_state_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } acs_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } acs_apb_rsp_s;
endpackage

// ===== rtl/acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - code 001 starts self-cal, ready held
// - self-cal shorts input, offset 3 or 4
// - then reference across capacitor, three conversions
// - self-cal end: mode 000, input reconnected
// - three fill conversions, then ready low
// - code 010: system offset, 3 or 4
// - system cal end: mode 000, one conversion
// - code 011: system full-scale, 3 or 4
// - code 100: offset on input, reference gain
// - pseudo end: mode 000, three fills, valid
// - code 101: background, first slave offset four
// - background loops offset, fill, gain, fill
// - background runs until host rewrites mode
// - background valid data at one seventh rate
// - results kept in offset, full-scale registers
// - host writes to calibration registers used
module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire acs_apb_req_s apb_req,
    output acs_apb_rsp_s      apb_rsp,
    input  wire logic         slave_mode,
    input  wire logic [23:0]  conv_result,
    output logic              data_ready_n,
    output logic              cap_short,
    output logic              cap_reference,
    output logic              conv_tick,
    output logic [23:0]       offset_corr,
    output logic [23:0]       fscale_corr
);
    // ==========================================================
    // state
    typedef struct packed {
        acs_state_e  st;
        logic [2:0]  mode;
        logic [2:0]  pend_mode;
        logic        pend;
        logic [2:0]  cnt;
        logic        bg_gain_next;
        logic        bg_first;
        logic [15:0] period;
        logic [15:0] tick_cnt;
        logic [23:0] ofs;
        logic [23:0] fs;
        logic        rdy_n;
        logic        sh;
        logic        rf;
        logic        tick;
        logic        ready;
        logic [31:0] rdata;
    } acs_regs_s;

    acs_regs_s r;
    acs_regs_s next_r;
    logic      access;
    logic      wr;
    logic      boundary;

    function automatic logic [2:0] ofs_len(input logic slv, input logic f);
        ofs_len = (slv && f) ? CAL_CONVS_SLV : CAL_CONVS;
    endfunction

    assign access   = apb_req.psel && apb_req.penable && !r.ready;
    assign wr       = access && apb_req.pwrite;
    assign boundary = (r.tick_cnt == 16'h0000);

    // ==========================================================
    // next-state logic
    always_comb begin
        next_r       = r;
        next_r.tick  = boundary;
        next_r.ready = access;
        // conversion-period timer
        next_r.tick_cnt = boundary ? r.period - 16'h0001
                                   : r.tick_cnt - 16'h0001;
        // register writes
        if (wr) begin
            case (apb_req.paddr)
                ADDR_MODE: begin
                    next_r.pend_mode = apb_req.pwdata[2:0];
                    next_r.pend      = 1'b1;
                end
                ADDR_OFFSET: next_r.ofs = apb_req.pwdata[23:0];
                ADDR_FSCALE: next_r.fs  = apb_req.pwdata[23:0];
                ADDR_CONV: begin
                    if (apb_req.pwdata[15:0] != 16'h0000) begin
                        next_r.period = apb_req.pwdata[15:0];
                    end
                end
                default: ;
            endcase
        end
        // reads
        if (access && !apb_req.pwrite) begin
            case (apb_req.paddr)
                ADDR_MODE:   next_r.rdata = {29'h0, r.mode};
                ADDR_STATUS: next_r.rdata = {27'h0, r.rdy_n, 1'b0,
                                             3'(r.st)};
                ADDR_OFFSET: next_r.rdata = {8'h00, r.ofs};
                ADDR_FSCALE: next_r.rdata = {8'h00, r.fs};
                ADDR_CONV:   next_r.rdata = {16'h0000, r.period};
                ADDR_RESULT: next_r.rdata = {8'h00, conv_result};
                default:     next_r.rdata = 32'h00000000;
            endcase
        end
        // sequencer steps once per conversion
        if (boundary) begin
            next_r.cnt = r.cnt - 3'h1;
            if (r.pend) begin
                // new code acts at this boundary
                next_r.pend  = 1'b0;
                next_r.mode  = r.pend_mode;
                next_r.rdy_n = 1'b1;
                next_r.sh    = 1'b0;
                next_r.rf    = 1'b0;
                next_r.bg_first = 1'b1;
                next_r.bg_gain_next = 1'b0;
                case (r.pend_mode)
                    MODE_SELF, MODE_BGND: begin
                        next_r.st  = ST_OFS;
                        next_r.sh  = 1'b1;
                        next_r.cnt = ofs_len(slave_mode, 1'b1);
                    end
                    MODE_SYSOFS, MODE_SYSFS, MODE_PSEUDO: begin
                        next_r.st  = ST_OFS;
                        next_r.cnt = ofs_len(slave_mode, 1'b1);
                    end
                    default: begin
                        // unused codes behave as normal conversion
                        next_r.mode  = MODE_NORMAL;
                        next_r.st    = ST_IDLE;
                        next_r.rdy_n = 1'b0;
                    end
                endcase
            end else begin
                case (r.st)
                    ST_IDLE: next_r.rdy_n = 1'b0;
                    ST_OFS: begin
                        if (r.cnt == 3'h1) begin
                            // offset result captured (full-scale result in system full-scale mode)
                            if (r.mode == MODE_SYSFS) begin
                                next_r.fs = conv_result;
                            end else begin
                                next_r.ofs = conv_result;
                            end
                            next_r.bg_first = 1'b0;
                            next_r.sh       = 1'b0;
                            case (r.mode)
                                MODE_SELF, MODE_PSEUDO: begin
                                    next_r.st  = ST_GAIN;
                                    next_r.rf  = 1'b1;
                                    next_r.cnt = CAL_CONVS;
                                end
                                MODE_BGND: begin
                                    next_r.st  = ST_FILL;
                                    next_r.cnt = FILL_CONVS;
                                    next_r.bg_gain_next = 1'b1;
                                end
                                default: begin
                                    next_r.mode = MODE_NORMAL;
                                    next_r.st   = ST_FILL;
                                    next_r.cnt  = SYS_FILL_CONVS;
                                end
                            endcase
                        end
                    end
                    ST_GAIN: begin
                        if (r.cnt == 3'h1) begin
                            next_r.fs  = conv_result;
                            next_r.rf  = 1'b0;
                            next_r.st  = ST_FILL;
                            next_r.cnt = FILL_CONVS;
                            if (r.mode != MODE_BGND) begin
                                next_r.mode = MODE_NORMAL;
                            end else begin
                                next_r.bg_gain_next = 1'b0;
                            end
                        end
                    end
                    ST_FILL: begin
                        if (r.cnt == 3'h1) begin
                            next_r.rdy_n = 1'b0;
                            next_r.st = (r.mode == MODE_BGND) ? ST_VALID
                                                              : ST_IDLE;
                        end
                    end
                    ST_VALID: begin
                        // one valid conversion then next cal
                        next_r.rdy_n = 1'b1;
                        if (r.bg_gain_next) begin
                            next_r.st  = ST_GAIN;
                            next_r.rf  = 1'b1;
                            next_r.cnt = CAL_CONVS;
                        end else begin
                            next_r.st  = ST_OFS;
                            next_r.sh  = 1'b1;
                            next_r.cnt = ofs_len(slave_mode, 1'b0);
                        end
                    end
                    default: next_r.st = ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.st       <= ST_IDLE;
            r.period   <= CONV_CYC_DEF;
            r.tick_cnt <= CONV_CYC_DEF;
            r.ofs      <= OFFSET_RST;
            r.fs       <= FSCALE_RST;
            r.rdy_n    <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // outputs
    assign apb_rsp.pready  = r.ready;
    assign apb_rsp.pslverr = 1'b0;
    assign apb_rsp.prdata  = r.rdata;
    assign data_ready_n    = r.rdy_n;
    assign cap_short       = r.sh;
    assign cap_reference   = r.rf;
    assign conv_tick       = r.tick;
    assign offset_corr     = r.ofs;
    assign fscale_corr     = r.fs;

    // ==========================================================
    // checks
    a_cap_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
        !(cap_short && cap_reference))
        else $error("capacitor shorted and on reference together");
    a_ready_in_cal: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == ST_OFS || r.st == ST_GAIN) |-> data_ready_n)
        else $error("data ready low during calibration");
    a_mode_cleared: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_IDLE && !r.pend && boundary) |=> r.mode == MODE_NORMAL)
        else $error("mode not cleared after calibration");
    a_bg_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r.mode == MODE_BGND && !wr && !r.pend) |=> r.mode == MODE_BGND)
        else $error("background mode dropped");
    a_late_act: assert property (@(posedge pclk) disable iff (!presetn)
        (r.pend && !boundary) |=> $stable(r.st))
        else $error("mode acted between boundaries");
    a_gain_ref: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == ST_GAIN) |-> cap_reference)
        else $error("gain cal without reference");
    a_valid_one: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == ST_VALID && boundary && !r.pend) |=> data_ready_n)
        else $error("valid slot longer than one conversion");
    a_cnt_len: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == ST_GAIN) |-> r.cnt <= CAL_CONVS)
        else $error("gain count too long");
endmodule
`default_nettype wire

// ===== sim/acs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host controller model on the register bus
module acs_host_model
    import acs_pkg::*;
(
    input  wire logic         pclk,
    output var acs_apb_req_s  apb_req,
    input  wire acs_apb_rsp_s apb_rsp
);
    // bus idle from time zero
    initial begin
        apb_req = '0;
    end

    // setup, access, hold until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] wdata,
                        output logic [31:0] rdata);
        @(posedge pclk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= addr;
        apb_req.pwdata  <= wdata;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1) @(posedge pclk);
        rdata = apb_rsp.prdata;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== sim/adc_calibration_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the calibration sequencer
module adc_calibration_sequencer_test
    import acs_pkg::*;
;
    localparam int PER = 8; // shortened conversion period
    logic         pclk;
    logic         presetn;
    logic         slave_mode;
    logic         data_ready_n;
    logic         cap_short;
    logic         cap_reference;
    logic         conv_tick;
    logic [23:0]  conv_result;
    logic [23:0]  offset_corr;
    logic [23:0]  fscale_corr;
    logic [31:0]  rd;
    acs_apb_req_s apb_req;
    acs_apb_rsp_s apb_rsp;
    int           error_cnt;
    int           total_checks;
    int           w;

    acs_sequencer u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .slave_mode(slave_mode),
        .conv_result(conv_result), .data_ready_n(data_ready_n),
        .cap_short(cap_short), .cap_reference(cap_reference),
        .conv_tick(conv_tick), .offset_corr(offset_corr),
        .fscale_corr(fscale_corr));
    acs_host_model u_host (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        u_host.xfer(1'b0, a, 32'h0, rd);
        chk(rd, e, "register read");
    endtask

    // wait for ready to rise, then count the high span and phases
    task automatic span(input int n_hi, input int n_sh, input int n_rf);
        int hi;
        int sh;
        int rf;
        hi = 0;
        sh = 0;
        rf = 0;
        w = 0;
        while (data_ready_n !== 1'b1 && w < 4 * PER) begin
            @(posedge pclk);
            w++;
        end
        while (data_ready_n === 1'b1 && hi < 40 * PER) begin
            hi++;
            sh += int'(cap_short === 1'b1);
            rf += int'(cap_reference === 1'b1);
            @(posedge pclk);
        end
        chk(32'(hi), 32'(n_hi * PER), "ready high span");
        chk(32'(sh), 32'(n_sh * PER), "shorted span");
        chk(32'(rf), 32'(n_rf * PER), "reference span");
    endtask

    // request one calibration code and measure it
    task automatic cal(input logic [2:0] c, input int h, input int s,
                       input int r);
        wr(ADDR_MODE, {29'h0, c});
        span(h, s, r);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        repeat (12000) @(posedge pclk);
        error_cnt++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        slave_mode = 1'b0;
        conv_result = 24'h0000a5;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ADDR_OFFSET, {8'h0, OFFSET_RST});
        rdchk(ADDR_FSCALE, {8'h0, FSCALE_RST});
        rdchk(ADDR_STATUS, 32'h00000010);
        rdchk(ADDR_RESULT, 32'h000000a5);
        wr(8'h18, 32'hffffffff);
        rdchk(8'h18, 32'h0);
        w = 0;
        while (data_ready_n !== 1'b0 && w < 1100) begin
            @(posedge pclk);
            w++;
        end
        wr(ADDR_CONV, 32'(PER));
        wr(ADDR_CONV, 32'h0);
        rdchk(ADDR_CONV, 32'(PER));
        repeat (2) begin
            w = 0;
            @(posedge pclk);
            while (conv_tick !== 1'b1 && w < 1100) begin
                @(posedge pclk);
                w++;
            end
        end
        // recalibrate after the rate change
        cal(MODE_SELF, 9, 3, 3);
        rdchk(ADDR_MODE, 32'h0);
        chk({8'h0, offset_corr}, 32'h0000a5, "self offset");
        chk({8'h0, fscale_corr}, 32'h0000a5, "self gain");
        conv_result <= 24'h000123;
        slave_mode <= 1'b1;
        cal(MODE_SYSOFS, 5, 0, 0);
        slave_mode <= 1'b0;
        rdchk(ADDR_OFFSET, 32'h000123);
        conv_result <= 24'h7fff00;
        cal(MODE_SYSFS, 4, 0, 0);
        rdchk(ADDR_MODE, 32'h0);
        chk({8'h0, fscale_corr}, 32'h7fff00, "system gain");
        cal(MODE_PSEUDO, 9, 0, 3);
        rdchk(ADDR_MODE, 32'h0);
        wr(ADDR_OFFSET, 32'h00123456);
        chk({8'h0, offset_corr}, 32'h00123456, "host offset");
        cal(MODE_BGND, 6, 3, 0);
        w = 0;
        while (data_ready_n === 1'b0 && w < 4 * PER) begin
            @(posedge pclk);
            w++;
        end
        chk(32'(w), 32'(PER), "valid span");
        span(6, 0, 3);
        span(6, 3, 0);
        rdchk(ADDR_MODE, {29'h0, MODE_BGND});
        wr(ADDR_MODE, 32'h0);
        repeat (3 * PER) @(posedge pclk);
        rdchk(ADDR_MODE, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
